/* File: src/tco_map.svh */
// Register offsets, reset values and channel count of the timer channel block
// Functional notes
// - Idle event counter holds its value
// - Event start loads data into counter
// - Event mode decrements per rising input edge
// - Filter adds two clocks of edge latency
// - Capture starts next clock, counter loads zero
// - Start interrupt when start select set
// - Capture edge copies counter, interrupts, restarts
// - One-count waits rising edge, loads data
// - One-count at zero interrupts, sets ones, waits for next rising edge
// - Width mode rising edge clears, counts up
// - Width mode falling edge captures, interrupts
// - Master output mode toggles on own interrupt
// - Slave output mode set/reset by polarity
// - Simultaneous set and reset: reset wins
// - Output enabled ignores software output writes
// - Output disabled takes writes, ignores interrupts
// - Output level register always readable
// - Eight channels, even ones are masters
// - Unfiltered edge seen three to four clocks later
// - Filter passes level stable two clocks
`ifndef TCO_MAP_SVH
`define TCO_MAP_SVH
`define TCO_NCH 8
`define TCO_OFF_START 8'h00
`define TCO_OFF_STOP 8'h04
`define TCO_OFF_MODE 8'h08
`define TCO_OFF_MDSEL 8'h0C
`define TCO_OFF_NFEN 8'h10
`define TCO_OFF_OUTLVL 8'h14
`define TCO_OFF_OUTEN 8'h18
`define TCO_OFF_OUTPOL 8'h1C
`define TCO_OFF_OUTMODE 8'h20
`define TCO_OFF_DATA 8'h40
`define TCO_OFF_CNT 8'h60
`define TCO_CNT_RST 16'hFFFF
`define TCO_CNT_ZERO 16'h0000
`define TCO_CNT_ONE 16'h0001
`define TCO_DATA_RST 16'h0000
`define TCO_BYTE_RST 8'h00
`define TCO_MODE_RST 16'h0000
`define TCO_WORD_RST 32'h0000_0000
`endif

/* File: src/tco_pkg.sv */
// Types shared by the timer channel block
`default_nettype none
package tco_pkg;
  typedef enum logic [1:0] {
    TCO_EVT = 2'b00,
    TCO_CAP = 2'b01,
    TCO_ONE = 2'b10,
    TCO_CAPONE = 2'b11
  } tco_mode_t;
  typedef enum logic [1:0] {
    TCO_IDLE = 2'b00,
    TCO_WAIT = 2'b01,
    TCO_RUN = 2'b10
  } tco_st_t;
  typedef struct packed {
    tco_mode_t mode;
    logic md;
    logic nf;
    logic oe;
    logic pol;
    logic om;
  } tco_cfg_t;
endpackage
`default_nettype wire

/* File: src/tco_top.sv */
// Eight-channel 16-bit timer with counting modes, channel outputs and APB slave
//
// The register addresses and the APB register port were decided locally.
`include "tco_map.svh"
`default_nettype none
module tco_top
  import tco_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] tin_pin,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  output var logic [7:0] tout_pin,
  output var logic [7:0] irq_pulse
);
  localparam int N = `TCO_NCH;

  // Master of a slave channel is the nearest even channel below it
  function automatic int master_idx(input int i);
    return (i == 0) ? 0 : ((i - 1) & 6);
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic addr_map_ok(input logic [7:0] a);
    return (a <= `TCO_OFF_OUTMODE && a[1:0] == 2'b00) ||
      (a >= `TCO_OFF_DATA && a < 8'h80 && a[1:0] == 2'b00);
  endfunction

  // Configuration registers
  logic [15:0] mode_reg, mode_next;
  logic [7:0] mdsel_reg, mdsel_next;
  logic [7:0] nfen_reg, nfen_next;
  logic [7:0] oe_reg, oe_next;
  logic [7:0] pol_reg, pol_next;
  logic [7:0] om_reg, om_next;
  tco_cfg_t cfg [N];

  // Channel state
  tco_st_t st_reg [N];
  tco_st_t st_next [N];
  logic [15:0] cnt_reg [N];
  logic [15:0] cnt_next [N];
  logic [15:0] data_reg [N];
  logic [15:0] data_next [N];
  logic [7:0] intr_next;
  logic [7:0] enabled;

  // Input synchroniser and filter
  logic [7:0] s1_reg, s2_reg, s3_reg;
  logic [7:0] f1_reg, f1_next, f2_reg;
  logic [7:0] lvl_reg, lvl_next, lvl_d_reg;
  logic [7:0] rise, fall;

  // Output and bus
  logic [7:0] olvl_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic acc, wr;

  assign acc = psel & penable;
  assign wr = acc & pwrite & pready;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      cfg[i].mode = tco_mode_t'(mode_reg[2*i +: 2]);
      cfg[i].md = mdsel_reg[i];
      cfg[i].nf = nfen_reg[i];
      cfg[i].oe = oe_reg[i];
      cfg[i].pol = pol_reg[i];
      cfg[i].om = om_reg[i];
      enabled[i] = st_reg[i] != TCO_IDLE;
    end
  end

  // Edge detection from the accepted input level
  always_comb begin
    for (int i = 0; i < N; i++) begin
      f1_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : f1_reg[i];
      if (cfg[i].nf) begin
        lvl_next[i] = (f1_reg[i] == f2_reg[i]) ? f2_reg[i] : lvl_reg[i];
      end else begin
        lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
      end
      rise[i] = lvl_reg[i] & ~lvl_d_reg[i];
      fall[i] = ~lvl_reg[i] & lvl_d_reg[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= `TCO_BYTE_RST;
      s2_reg <= `TCO_BYTE_RST;
      s3_reg <= `TCO_BYTE_RST;
      f1_reg <= `TCO_BYTE_RST;
      f2_reg <= `TCO_BYTE_RST;
      lvl_reg <= `TCO_BYTE_RST;
      lvl_d_reg <= `TCO_BYTE_RST;
    end else begin
      s1_reg <= tin_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f1_reg <= f1_next;
      f2_reg <= f1_reg;
      lvl_reg <= lvl_next;
      lvl_d_reg <= lvl_reg;
    end
  end

  // Counting modes
  always_comb begin
    for (int i = 0; i < N; i++) begin
      st_next[i] = st_reg[i];
      cnt_next[i] = cnt_reg[i];
      data_next[i] = data_reg[i];
      intr_next[i] = 1'b0;
      if (wr && addr_is(paddr, `TCO_OFF_DATA + 8'(4 * i))) begin
        data_next[i] = pwdata[15:0];
      end
      case (st_reg[i])
        TCO_IDLE: begin
          if (wr && addr_is(paddr, `TCO_OFF_START) && pwdata[i]) begin
            if (cfg[i].mode == TCO_EVT) begin
              cnt_next[i] = data_reg[i];
              st_next[i] = TCO_RUN;
            end else begin
              st_next[i] = TCO_WAIT;
            end
          end
        end
        TCO_WAIT: begin
          case (cfg[i].mode)
            TCO_CAP: begin
              cnt_next[i] = `TCO_CNT_ZERO;
              intr_next[i] = cfg[i].md;
              st_next[i] = TCO_RUN;
            end
            TCO_ONE: begin
              if (rise[i]) begin
                cnt_next[i] = data_reg[i];
                st_next[i] = TCO_RUN;
              end
            end
            TCO_CAPONE: begin
              if (rise[i]) begin
                cnt_next[i] = `TCO_CNT_ZERO;
                st_next[i] = TCO_RUN;
              end
            end
            default: begin
              st_next[i] = TCO_RUN;
            end
          endcase
        end
        TCO_RUN: begin
          case (cfg[i].mode)
            TCO_EVT: begin
              if (rise[i]) begin
                cnt_next[i] = cnt_reg[i] - `TCO_CNT_ONE;
              end
            end
            TCO_CAP: begin
              if (rise[i]) begin
                data_next[i] = cnt_reg[i];
                intr_next[i] = 1'b1;
                cnt_next[i] = `TCO_CNT_ZERO;
              end else begin
                cnt_next[i] = cnt_reg[i] + `TCO_CNT_ONE;
              end
            end
            TCO_ONE: begin
              if (cnt_reg[i] == `TCO_CNT_ZERO) begin
                intr_next[i] = 1'b1;
                cnt_next[i] = `TCO_CNT_RST;
                st_next[i] = TCO_WAIT;
              end else begin
                cnt_next[i] = cnt_reg[i] - `TCO_CNT_ONE;
              end
            end
            default: begin
              if (fall[i]) begin
                data_next[i] = cnt_reg[i];
                intr_next[i] = 1'b1;
                st_next[i] = TCO_WAIT;
              end else begin
                cnt_next[i] = cnt_reg[i] + `TCO_CNT_ONE;
              end
            end
          endcase
        end
        default: begin
          st_next[i] = TCO_IDLE;
        end
      endcase
      // Stopping returns the channel to idle; the counter keeps its value
      if (wr && addr_is(paddr, `TCO_OFF_STOP) && pwdata[i]) begin
        st_next[i] = TCO_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        st_reg[i] <= TCO_IDLE;
        cnt_reg[i] <= `TCO_CNT_RST;
        data_reg[i] <= `TCO_DATA_RST;
      end
      irq_pulse <= `TCO_BYTE_RST;
    end else begin
      for (int i = 0; i < N; i++) begin
        st_reg[i] <= st_next[i];
        cnt_reg[i] <= cnt_next[i];
        data_reg[i] <= data_next[i];
      end
      irq_pulse <= intr_next;
    end
  end

  // Channel output flip-flops, driven from the registered interrupts
  always_comb begin
    for (int i = 0; i < N; i++) begin
      olvl_next[i] = tout_pin[i];
      if (cfg[i].oe) begin
        if (!cfg[i].om) begin
          if (irq_pulse[i]) begin
            olvl_next[i] = ~tout_pin[i];
          end
        end else if (irq_pulse[master_idx(i)] && irq_pulse[i]) begin
          olvl_next[i] = cfg[i].pol;
        end else if (irq_pulse[master_idx(i)]) begin
          olvl_next[i] = ~cfg[i].pol;
        end else if (irq_pulse[i]) begin
          olvl_next[i] = cfg[i].pol;
        end
      end else if (wr && addr_is(paddr, `TCO_OFF_OUTLVL)) begin
        olvl_next[i] = pwdata[i];
      end
    end
  end

  // APB slave: one wait state, writes land on the completing edge
  always_comb begin
    mode_next = mode_reg;
    mdsel_next = mdsel_reg;
    nfen_next = nfen_reg;
    oe_next = oe_reg;
    pol_next = pol_reg;
    om_next = om_reg;
    if (wr) begin
      case (paddr)
        `TCO_OFF_MODE: mode_next = pwdata[15:0];
        `TCO_OFF_MDSEL: mdsel_next = pwdata[7:0];
        `TCO_OFF_NFEN: nfen_next = pwdata[7:0];
        `TCO_OFF_OUTEN: oe_next = pwdata[7:0];
        `TCO_OFF_OUTPOL: pol_next = pwdata[7:0];
        `TCO_OFF_OUTMODE: om_next = pwdata[7:0];
        default: begin
        end
      endcase
    end
    pready_next = acc & ~pready;
    pslverr_next = acc & ~pready & ~addr_map_ok(paddr);
    prdata_next = prdata;
    if (acc && !pready) begin
      prdata_next = `TCO_WORD_RST;
      case (paddr)
        `TCO_OFF_START: prdata_next[7:0] = enabled;
        `TCO_OFF_MODE: prdata_next[15:0] = mode_reg;
        `TCO_OFF_MDSEL: prdata_next[7:0] = mdsel_reg;
        `TCO_OFF_NFEN: prdata_next[7:0] = nfen_reg;
        `TCO_OFF_OUTLVL: prdata_next[7:0] = tout_pin;
        `TCO_OFF_OUTEN: prdata_next[7:0] = oe_reg;
        `TCO_OFF_OUTPOL: prdata_next[7:0] = pol_reg;
        `TCO_OFF_OUTMODE: prdata_next[7:0] = om_reg;
        default: begin
          for (int i = 0; i < N; i++) begin
            if (addr_is(paddr, `TCO_OFF_DATA + 8'(4 * i))) begin
              prdata_next[15:0] = data_reg[i];
            end
            if (addr_is(paddr, `TCO_OFF_CNT + 8'(4 * i))) begin
              prdata_next[15:0] = cnt_reg[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `TCO_MODE_RST;
      mdsel_reg <= `TCO_BYTE_RST;
      nfen_reg <= `TCO_BYTE_RST;
      oe_reg <= `TCO_BYTE_RST;
      pol_reg <= `TCO_BYTE_RST;
      om_reg <= `TCO_BYTE_RST;
      tout_pin <= `TCO_BYTE_RST;
      prdata <= `TCO_WORD_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      mdsel_reg <= mdsel_next;
      nfen_reg <= nfen_next;
      oe_reg <= oe_next;
      pol_reg <= pol_next;
      om_reg <= om_next;
      tout_pin <= olvl_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // Checks on channels 0 to 3, the ones the bench exercises per mode
  logic start0, stop0, olw;
  logic [15:0] cnt0, data0;
  assign start0 = wr && addr_is(paddr, `TCO_OFF_START) && pwdata[0];
  assign stop0 = wr && addr_is(paddr, `TCO_OFF_STOP) && pwdata[0];
  assign olw = wr && addr_is(paddr, `TCO_OFF_OUTLVL);
  assign cnt0 = cnt_reg[0];
  assign data0 = data_reg[0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_hold;
    st_reg[0] == TCO_IDLE && !start0 |=> cnt0 == $past(cnt0);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle counter moved");

  property p_evt_load;
    st_reg[0] == TCO_IDLE && start0 && cfg[0].mode == TCO_EVT
      |=> cnt0 == $past(data0) && st_reg[0] == TCO_RUN;
  endproperty
  a_evt_load: assert property (p_evt_load) else $error("event start did not load");

  property p_evt_dec;
    st_reg[0] == TCO_RUN && cfg[0].mode == TCO_EVT && rise[0]
      |=> cnt0 == $past(cnt0) - `TCO_CNT_ONE;
  endproperty
  a_evt_dec: assert property (p_evt_dec) else $error("event count not decremented");

  property p_cap_start;
    st_reg[1] == TCO_WAIT && cfg[1].mode == TCO_CAP
      |=> cnt_reg[1] == `TCO_CNT_ZERO && irq_pulse[1] == $past(cfg[1].md);
  endproperty
  a_cap_start: assert property (p_cap_start) else $error("capture start wrong");

  property p_cap_edge;
    st_reg[1] == TCO_RUN && cfg[1].mode == TCO_CAP && rise[1]
      |=> data_reg[1] == $past(cnt_reg[1]) && irq_pulse[1] && cnt_reg[1] == `TCO_CNT_ZERO;
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("capture edge wrong");

  property p_one_end;
    st_reg[2] == TCO_RUN && cfg[2].mode == TCO_ONE && cnt_reg[2] == `TCO_CNT_ZERO
      |=> irq_pulse[2] && cnt_reg[2] == `TCO_CNT_RST ##1 $stable(cnt_reg[2]);
  endproperty
  a_one_end: assert property (p_one_end) else $error("one-count end wrong");

  property p_prio;
    oe_reg[3] && om_reg[3] && irq_pulse[2] && irq_pulse[3] |=> tout_pin[3] == $past(pol_reg[3]);
  endproperty
  a_prio: assert property (p_prio) else $error("reset did not win");

  property p_oe_off;
    !oe_reg[0] && !olw |=> $stable(tout_pin[0]);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("disabled output changed");

  sequence s_pin_up;
    !nfen_reg[0] && !lvl_reg[0] && s2_reg[0] && s3_reg[0];
  endsequence
  property p_sync;
    s_pin_up |=> lvl_reg[0] && rise[0];
  endproperty
  a_sync: assert property (p_sync) else $error("input edge latency wrong");

  property p_filter;
    nfen_reg[0] && f1_reg[0] != f2_reg[0] |=> $stable(lvl_reg[0]);
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed unstable level");
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the eight-channel timer block
`include "tco_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] tin;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] tout;
  logic [7:0] irq;
  int fails = 0;
  int checked = 0;
  int irq_cnt [8] = '{default: 0};

  always #25 pclk = ~pclk;

  tco_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tin_pin(tin),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tout_pin(tout), .irq_pulse(irq)
  );
  tco_pulse_src src (.pclk(pclk), .tin(tin));

  always @(posedge pclk) begin
    for (int i = 0; i < 8; i++) begin
      if (irq[i] === 1'b1) irq_cnt[i]++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
                         input logic [31:0] hi);
    checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim;
  end

  initial begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`TCO_OFF_CNT, 32'h0000_FFFF);
    rdc(`TCO_OFF_DATA + 8'h1C, 32'h0000_0000);
    rdc(`TCO_OFF_OUTLVL, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
    wr(`TCO_OFF_DATA + 8'h1C, 32'h1234_ABCD);
    rdc(`TCO_OFF_DATA + 8'h1C, 32'h0000_ABCD);
    done("reset and map");
    wr(`TCO_OFF_DATA, 32'h0000_0005);
    src.pulse(0, 2, 3);
    rdc(`TCO_OFF_CNT, 32'h0000_FFFF);
    wr(`TCO_OFF_START, 32'h0000_0001);
    rdc(`TCO_OFF_CNT, 32'h0000_0005);
    rdc(`TCO_OFF_START, 32'h0000_0001);
    repeat (3) src.pulse(0, 2, 3);
    idle(8);
    rdc(`TCO_OFF_CNT, 32'h0000_0002);
    wr(`TCO_OFF_NFEN, 32'h0000_0001);
    src.pulse(0, 1, 8);
    rdc(`TCO_OFF_CNT, 32'h0000_0002);
    src.pulse(0, 4, 10);
    rdc(`TCO_OFF_CNT, 32'h0000_0001);
    wr(`TCO_OFF_START, 32'h0000_0001);
    rdc(`TCO_OFF_CNT, 32'h0000_0001);
    wr(`TCO_OFF_STOP, 32'h0000_0001);
    done("event counter");
    wr(`TCO_OFF_OUTMODE, 32'h0000_0008);
    wr(`TCO_OFF_OUTPOL, 32'h0000_0000);
    wr(`TCO_OFF_OUTLVL, 32'h0000_0000);
    wr(`TCO_OFF_OUTEN, 32'h0000_000C);
    wr(`TCO_OFF_OUTLVL, 32'h0000_001C);
    rdc(`TCO_OFF_OUTLVL, 32'h0000_0010);
    chk(32'(tout), 32'h0000_0010);
    wr(`TCO_OFF_MODE, 32'h0000_00E4);
    done("output setup");
    wr(`TCO_OFF_DATA + 8'h08, 32'h0000_0006);
    wr(`TCO_OFF_START, 32'h0000_0004);
    idle(6);
    rdc(`TCO_OFF_CNT + 8'h08, 32'h0000_FFFF);
    src.pulse(2, 2, 2);
    apb(1'b0, `TCO_OFF_CNT + 8'h08, 32'h0000_0000, r, e);
    chk_rng(r, 32'h0000_0001, 32'h0000_0006);
    idle(20);
    rdc(`TCO_OFF_CNT + 8'h08, 32'h0000_FFFF);
    chk(32'(irq_cnt[2]), 32'h0000_0001);
    chk(32'(tout), 32'h0000_001C);
    done("one-count");
    wr(`TCO_OFF_START, 32'h0000_0008);
    src.pulse(3, 10, 10);
    apb(1'b0, `TCO_OFF_DATA + 8'h0C, 32'h0000_0000, r, e);
    chk_rng(r, 32'h0000_0008, 32'h0000_000B);
    chk(32'(irq_cnt[3]), 32'h0000_0001);
    chk(32'(tout), 32'h0000_0014);
    done("width");
    wr(`TCO_OFF_OUTEN, 32'h0000_0000);
    src.pulse(2, 2, 20);
    chk(32'(irq_cnt[2]), 32'h0000_0002);
    chk(32'(tout), 32'h0000_0014);
    wr(`TCO_OFF_OUTLVL, 32'h0000_0001);
    rdc(`TCO_OFF_OUTLVL, 32'h0000_0001);
    done("output gating");
    wr(`TCO_OFF_MDSEL, 32'h0000_0002);
    wr(`TCO_OFF_START, 32'h0000_0002);
    idle(4);
    chk(32'(irq_cnt[1]), 32'h0000_0001);
    idle(10);
    src.pulse(1, 2, 8);
    chk(32'(irq_cnt[1]), 32'h0000_0002);
    apb(1'b0, `TCO_OFF_CNT + 8'h04, 32'h0000_0000, r, e);
    chk_rng(r, 32'h0000_0002, 32'h0000_0010);
    apb(1'b0, `TCO_OFF_DATA + 8'h04, 32'h0000_0000, r, e);
    chk_rng(r, 32'h0000_000E, 32'h0000_0030);
    done("capture");
    wr(`TCO_OFF_MODE, 32'h0000_00A4);
    wr(`TCO_OFF_DATA + 8'h0C, 32'h0000_0006);
    wr(`TCO_OFF_OUTLVL, 32'h0000_0008);
    wr(`TCO_OFF_OUTEN, 32'h0000_000C);
    src.pulse_mask(8'h0C, 2, 20);
    chk(32'(irq_cnt[2]), 32'h0000_0003);
    chk(32'(irq_cnt[3]), 32'h0000_0002);
    chk(32'(tout), 32'h0000_0004);
    done("set and reset together");
    end_sim;
  end
endmodule
`default_nettype wire

/* File: test/tco_pulse_src.sv */
// Pulse source model that drives the timer input pins
`default_nettype none
module tco_pulse_src (
  input wire logic pclk,
  output var logic [7:0] tin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial tin = 8'h00;
  // Whole-cycle high and low spans, so callers pick prompt or slow edges
  task automatic pulse(input int ch, input int hi, input int lo);
    @(posedge pclk);
    tin[ch] <= 1'b1;
    repeat (hi) @(posedge pclk);
    tin[ch] <= 1'b0;
    repeat (lo) @(posedge pclk);
  endtask
  // Several pins pulsed together, so channels see their edges in one cycle
  task automatic pulse_mask(input logic [7:0] m, input int hi, input int lo);
    @(posedge pclk);
    tin <= tin | m;
    repeat (hi) @(posedge pclk);
    tin <= tin & ~m;
    repeat (lo) @(posedge pclk);
  endtask
endmodule
`default_nettype wire
